// ### hdl/nvc_cfg.svh
// timing counts and field positions for the nvsram host controller
`ifndef NVC_CFG_SVH
`define NVC_CFG_SVH
`define NVC_CLK_NS             25
`define NVC_ADDR_W             15
`define NVC_DATA_W             8
`define NVC_SEQ_LEN            6
// pin cycle length and strobe width in ns, rounded up to clocks
`define NVC_ACC_NS             50
`define NVC_ACC_CYC            ((`NVC_ACC_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
`define NVC_HSB_PULSE_NS       15
`define NVC_HSB_PULSE_CYC      ((`NVC_HSB_PULSE_NS + `NVC_CLK_NS - 1) / `NVC_CLK_NS)
// waits in us, longest times rounded down
`define NVC_SOFT_LAT_US        70
`define NVC_SOFT_LAT_CYC       ((`NVC_SOFT_LAT_US * 1000) / `NVC_CLK_NS)
`define NVC_SOFT_RECALL_US     120
`define NVC_SOFT_RECALL_CYC    ((`NVC_SOFT_RECALL_US * 1000) / `NVC_CLK_NS)
`define NVC_DRAIN_US           70
`define NVC_DRAIN_CYC          ((`NVC_DRAIN_US * 1000) / `NVC_CLK_NS)
`define NVC_STORE_US           15000
`define NVC_STORE_CYC          ((`NVC_STORE_US * 1000) / `NVC_CLK_NS)
`define NVC_PUP_RECALL_US      20000
`define NVC_PUP_RECALL_CYC     ((`NVC_PUP_RECALL_US * 1000) / `NVC_CLK_NS)
`define NVC_CMD_READ           2'h0
`define NVC_CMD_WRITE          2'h1
`define NVC_CMD_SW_STORE       2'h2
`define NVC_CMD_SW_RECALL      2'h3
`endif

// ### hdl/nvc_pkg.sv
// types of the nvsram host controller
`include "nvc_cfg.svh"
package nvc_pkg;
	typedef struct packed {
		logic [1:0]              cmd;
		logic [`NVC_ADDR_W-1:0]  addr;
		logic [`NVC_DATA_W-1:0]  wdata;
	} nvc_req_t;
	typedef struct packed {
		logic                    ce_n;
		logic                    oe_n;
		logic                    we_n;
		logic [`NVC_ADDR_W-1:0]  addr;
		logic [`NVC_DATA_W-1:0]  dq_o;
		logic                    dq_oe;
	} nvc_pins_t;
	typedef enum logic [2:0] {
		NVC_BOOT, NVC_IDLE, NVC_ACC, NVC_GAP, NVC_WAIT_BUSY, NVC_BUSY, NVC_HSB_PULSE
	} nvc_state_t;
endpackage

// ### hdl/nvc_host.sv
// host controller driving an nvsram over its asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "nvc_cfg.svh"
// Function
// - write strobe stays high during every read cycle we drive
// - store/busy line released high during all our read and write cycles
// - software command is six sequence reads back to back, in order
// - write strobe high for all six sequence reads
// - hardware store request pulse held low at least its minimum
module nvc_host
	import nvc_pkg::*;
#(
	parameter int unsigned STORE_CYC    = `NVC_STORE_CYC,
	parameter int unsigned PUP_CYC      = `NVC_PUP_RECALL_CYC,
	parameter int unsigned SOFT_LAT_CYC = `NVC_SOFT_LAT_CYC,
	parameter int unsigned RECALL_CYC   = `NVC_SOFT_RECALL_CYC,
	parameter int unsigned DRAIN_CYC    = `NVC_DRAIN_CYC,
	parameter logic [`NVC_ADDR_W*`NVC_SEQ_LEN-1:0] STORE_SEQ  = '0,
	parameter logic [`NVC_ADDR_W*`NVC_SEQ_LEN-1:0] RECALL_SEQ = '0
) (
	input  wire logic                   clk_sys,
	input  wire logic                   rst_b,
	input  wire logic                   supply_ok,
	input  wire logic                   req_valid,
	input  wire nvc_req_t               req,
	output var  logic                   req_ready,
	input  wire logic                   hw_store_req,
	output var  logic                   rsp_valid,
	output var  logic [`NVC_DATA_W-1:0] rsp_rdata,
	output var  logic                   rsp_timeout,
	output var  nvc_pins_t              pins,
	input  wire logic [`NVC_DATA_W-1:0] dq_i,
	input  wire logic                   hsb_i,
	output var  logic                   hw_store_busy_n_o,
	output var  logic                   hw_store_busy_n_oe
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [1:0]             hsb_s_q;
	logic [1:0]             sup_s_q;
	logic [`NVC_DATA_W-1:0] dq_s1_q;
	logic [`NVC_DATA_W-1:0] dq_s2_q;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hsb_s_q <= 2'h0;
			sup_s_q <= 2'h0;
			dq_s1_q <= '0;
			dq_s2_q <= '0;
		end else begin
			hsb_s_q <= {hsb_s_q[0], hsb_i};
			sup_s_q <= {sup_s_q[0], supply_ok};
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
		end
	end
	wire hsb_high = hsb_s_q[1];
	wire sup_high = sup_s_q[1];

	// ----------------------------------------
	// control state
	// ----------------------------------------
	nvc_state_t              st_q, st_d;
	logic [31:0]             cnt_q, cnt_d;
	logic [31:0]             lim_q, lim_d;
	logic [2:0]              seq_q, seq_d;
	logic                    seq_rec_q, seq_rec_d;
	nvc_req_t                cur_q, cur_d;
	nvc_pins_t               pins_d;
	logic                    rdy_d, rv_d, to_d, hsb_oe_d;
	logic [`NVC_DATA_W-1:0]  rd_d;

	function automatic logic [`NVC_ADDR_W-1:0] seq_addr(input logic rec, input logic [2:0] i);
		logic [`NVC_ADDR_W*`NVC_SEQ_LEN-1:0] tbl;
		tbl = rec ? RECALL_SEQ : STORE_SEQ;
		seq_addr = tbl[i*`NVC_ADDR_W +: `NVC_ADDR_W];
	endfunction

	wire is_soft   = cur_q.cmd[1];
	wire is_write  = (cur_q.cmd == `NVC_CMD_WRITE);
	wire cnt_done  = (cnt_q >= lim_q);
	wire last_seq  = (seq_q == 3'(`NVC_SEQ_LEN - 1));
	// ----------------------------------------
	// access gate
	// ----------------------------------------
	// busy and supply gate
	wire dev_free  = hsb_high && sup_high;
	// completion bound kept at full counter width so the long waits are not cut
	wire [31:0] soft_lim = (cur_q.cmd == `NVC_CMD_SW_RECALL) ?
		32'(RECALL_CYC) : 32'(STORE_CYC);

	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q + 32'h1;
		lim_d     = lim_q;
		seq_d     = seq_q;
		seq_rec_d = seq_rec_q;
		cur_d     = cur_q;
		pins_d    = pins;
		rdy_d     = 1'b0;
		rv_d      = 1'b0;
		to_d      = 1'b0;
		rd_d      = rsp_rdata;
		hsb_oe_d  = 1'b0;
		unique case (st_q)
			NVC_BOOT: begin
				if (!sup_high) begin
					cnt_d = 32'h0;
				end else if (cnt_q >= PUP_CYC && hsb_high) begin
					st_d  = NVC_IDLE;
					rdy_d = 1'b1;
				end
			end
			NVC_IDLE: begin
				rdy_d = dev_free;
				if (!sup_high) begin
					st_d  = NVC_BOOT;
					cnt_d = 32'h0;
					rdy_d = 1'b0;
				end else if (hw_store_req) begin
					st_d     = NVC_HSB_PULSE;
					cnt_d    = 32'h0;
					hsb_oe_d = 1'b1;
					rdy_d    = 1'b0;
				end else if (req_valid && dev_free) begin
					cur_d     = req;
					seq_d     = 3'h0;
					seq_rec_d = (req.cmd == `NVC_CMD_SW_RECALL);
					st_d      = NVC_ACC;
					cnt_d     = 32'h0;
					lim_d     = `NVC_ACC_CYC;
					rdy_d     = 1'b0;
					// chip select falls to frame each read
					pins_d.ce_n  = 1'b0;
					pins_d.oe_n  = req.cmd[0] && !req.cmd[1];
					pins_d.we_n  = !(req.cmd == `NVC_CMD_WRITE);
					pins_d.dq_oe = (req.cmd == `NVC_CMD_WRITE);
					pins_d.dq_o  = req.wdata;
					pins_d.addr  = req.cmd[1] ?
						seq_addr(req.cmd == `NVC_CMD_SW_RECALL, 3'h0) : req.addr;
				end
			end
			NVC_ACC: begin
				if (cnt_done) begin
					pins_d.ce_n  = 1'b1;
					pins_d.oe_n  = 1'b1;
					pins_d.we_n  = 1'b1;
					pins_d.dq_oe = 1'b0;
					rd_d         = dq_s2_q;
					st_d         = NVC_GAP;
					cnt_d        = 32'h0;
				end
			end
			NVC_GAP: begin
				// next sequence read with nothing between
				if (cnt_q >= 32'h2) begin
					if (is_soft && !last_seq) begin
						seq_d        = seq_q + 3'h1;
						pins_d.ce_n  = 1'b0;
						// output enable must fall again or the device sees no read
						pins_d.oe_n  = 1'b0;
						pins_d.addr  = seq_addr(seq_rec_q, 3'(seq_q + 3'h1));
						st_d         = NVC_ACC;
						cnt_d        = 32'h0;
					end else if (is_soft) begin
						st_d  = NVC_WAIT_BUSY;
						cnt_d = 32'h0;
						lim_d = SOFT_LAT_CYC;
					end else begin
						rv_d  = 1'b1;
						rdy_d = dev_free;
						st_d  = NVC_IDLE;
					end
				end
			end
			NVC_WAIT_BUSY: begin
				// a skipped store shows no busy at all
				// our own store pulse echoes through the synchroniser for one
				// cycle; ignore it or the store would look finished at once
				if (!hsb_high && cnt_q >= 32'h2) begin
					st_d  = NVC_BUSY;
					cnt_d = 32'h0;
					lim_d = is_soft ? soft_lim : STORE_CYC;
				end else if (cnt_done) begin
					rv_d = 1'b1;
					st_d = NVC_IDLE;
				end
			end
			NVC_BUSY: begin
				if (hsb_high) begin
					rv_d = 1'b1;
					st_d = NVC_IDLE;
				end else if (cnt_done) begin
					rv_d = 1'b1;
					to_d = 1'b1;
					st_d = NVC_IDLE;
				end
			end
			NVC_HSB_PULSE: begin
				hsb_oe_d = 1'b1;
				if (cnt_q >= 32'(`NVC_HSB_PULSE_CYC - 1)) begin
					hsb_oe_d = 1'b0;
					// device drains cycles in the window
					cur_d.cmd = `NVC_CMD_SW_STORE;
					st_d      = NVC_WAIT_BUSY;
					cnt_d     = 32'h0;
					lim_d     = DRAIN_CYC;
				end
			end
			default: begin
				st_d = NVC_BOOT;
			end
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_q               <= NVC_BOOT;
			cnt_q              <= 32'h0;
			lim_q              <= 32'h0;
			seq_q              <= 3'h0;
			seq_rec_q          <= 1'b0;
			cur_q              <= '0;
			pins               <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
			req_ready          <= 1'b0;
			rsp_valid          <= 1'b0;
			rsp_rdata          <= '0;
			rsp_timeout        <= 1'b0;
			hw_store_busy_n_oe <= 1'b0;
		end else begin
			st_q               <= st_d;
			cnt_q              <= cnt_d;
			lim_q              <= lim_d;
			seq_q              <= seq_d;
			seq_rec_q          <= seq_rec_d;
			cur_q              <= cur_d;
			pins               <= pins_d;
			req_ready          <= rdy_d;
			rsp_valid          <= rv_d;
			rsp_rdata          <= rd_d;
			rsp_timeout        <= to_d;
			hw_store_busy_n_oe <= hsb_oe_d;
		end
	end
	// open-drain: only ever drives low
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hw_store_busy_n_o <= 1'b0;
		end else begin
			hw_store_busy_n_o <= 1'b0;
		end
	end
endmodule
`default_nettype wire

// ### bench/nvc_chk.sv
// port assertions for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module nvc_chk
	import nvc_pkg::*;
(
	input wire logic      clk_sys,
	input wire logic      rst_b,
	input wire logic      supply_ok,
	input wire logic      req_ready,
	input wire logic      rsp_valid,
	input wire logic      rsp_timeout,
	input wire nvc_pins_t pins,
	input wire logic      hsb_i,
	input wire logic      hw_store_busy_n_o,
	input wire logic      hw_store_busy_n_oe
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	a_read_we_high: assert property (!pins.oe_n |-> pins.we_n)
		else $error("write strobe low in read");
	a_hsb_released: assert property (!pins.ce_n |-> !hw_store_busy_n_oe)
		else $error("store line pulled during access");
	a_hsb_pulse: assert property ($rose(hw_store_busy_n_oe) |->
		!hw_store_busy_n_o ##1 !hw_store_busy_n_oe) else $error("bad store pulse");
	a_frame_len: assert property ($fell(pins.ce_n) |-> !pins.ce_n[*2] ##[1:2] pins.ce_n)
		else $error("read frame length");
	a_read_oe_low: assert property ($fell(pins.ce_n) && pins.we_n |-> !pins.oe_n)
		else $error("read frame without output enable");
	a_addr_held: assert property (!pins.ce_n && !$past(pins.ce_n) |-> $stable(pins.addr))
		else $error("address moved in frame");
	a_supply_gate: assert property (!supply_ok [*5] |-> !req_ready)
		else $error("ready with supply low");
	a_busy_ready: assert property (!hsb_i [*5] |-> !req_ready)
		else $error("ready while busy");
	a_no_start_busy: assert property (!hsb_i [*4] |-> !$fell(pins.ce_n))
		else $error("access started while busy");
	a_timeout_rsp: assert property (rsp_timeout |-> rsp_valid ##1 !rsp_valid)
		else $error("timeout without response");
	c_hw_store: cover property ($rose(hw_store_busy_n_oe));
	c_timeout: cover property (rsp_timeout);
	c_low_supply: cover property (!supply_ok);
endmodule
bind nvc_host nvc_chk chk (.clk_sys, .rst_b, .supply_ok, .req_ready, .rsp_valid,
	.rsp_timeout, .pins, .hsb_i, .hw_store_busy_n_o, .hw_store_busy_n_oe);
`default_nettype wire

// ### bench/nvc_dev.sv
// behavioural nvsram facing the host controller
`timescale 1ns/1ps
`default_nettype none
module nvc_dev
	import nvc_pkg::*;
#(
	parameter logic [89:0] SSEQ = '0,
	parameter logic [89:0] RSEQ = '0
) (
	input  wire logic       clk_sys,
	input  wire nvc_pins_t  pins,
	input  wire logic       supply_ok,
	input  wire logic       slow,
	input  wire logic       hsb_w,
	output var  logic       busy,
	output wire logic [7:0] dq
);
	logic [7:0] mem [2**15];
	logic [7:0] nv [2**15];
	logic [7:0] last = 8'h00;
	logic dirty = 1'b0, rd_q = 1'b0, go_s = 1'b0, go_r = 1'b0, up_q = 1'b0;
	int s = 0, r = 0;
	wire ok = supply_ok && !busy;
	wire rd = ok && !pins.ce_n && !pins.oe_n && pins.we_n;
	wire [14:0] a = pins.addr;
	// data follows address while selected; a released bus shows the inverse
	assign dq = rd ? mem[a] : ~last;
	// gated access, step on read fall, writes break it
	always @(posedge clk_sys) begin
		rd_q <= rd;
		if (rd)
			last <= mem[a];
		go_s <= rd && !rd_q && s == 5 && a == SSEQ[89:75];
		go_r <= rd && !rd_q && r == 5 && a == RSEQ[89:75];
		if (ok && !pins.ce_n && !pins.we_n) begin
			mem[a] <= pins.dq_o;
			dirty <= 1'b1;
			s <= 0;
			r <= 0;
		end else if (rd && !rd_q) begin
			s <= a == SSEQ[s*15 +: 15] ? (s + 1) % 6 : int'(a == SSEQ[14:0]);
			r <= a == RSEQ[r*15 +: 15] ? (r + 1) % 6 : int'(a == RSEQ[14:0]);
		end
	end
	task automatic run(input int w, input bit st);
		repeat (w) @(posedge clk_sys);
		// nothing written since the last transfer: skip
		if (st && !dirty)
			return;
		// busy for the whole bounded transfer
		busy <= 1'b1;
		repeat (slow ? 90 : 1 + $urandom % 30) @(posedge clk_sys);
		if (st)
			nv = mem;
		else
			mem = nv;
		dirty = 1'b0;
		busy <= 1'b0;
	endtask
	initial begin
		busy = 1'b0;
		forever begin
			@(posedge clk_sys);
			// soft command acted on within the latency
			if (go_s || go_r)
				run(1 + $urandom % 20, go_s);
			// hardware store within the drain window
			else if (!hsb_w && !busy)
				run(40 + $urandom % 40, 1'b1);
			// recall counted from the supply rise
			else if (supply_ok && !up_q)
				run(0, 1'b0);
			up_q = supply_ok;
		end
	end
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`default_nettype none
module tb import nvc_pkg::*; ;
	localparam logic [89:0] SQ = {15'h0666, 15'h0555, 15'h0444, 15'h0333, 15'h0222, 15'h0111};
	localparam logic [89:0] RQ = {15'h0777, SQ[74:0]};
	logic clk_sys = 1'b0, rst_b = 1'b0, supply_ok = 1'b1, req_valid = 1'b0;
	logic hw_store_req = 1'b0, slow = 1'b0, req_ready, rsp_valid, rsp_timeout, hsb_o, hsb_oe, busy;
	logic [7:0] rsp_rdata, d;
	logic [7:0] shad [2**15];
	logic [7:0] nvsh [2**15];
	logic [14:0] a;
	nvc_req_t req = '0;
	nvc_pins_t pins;
	int errors = 0, checked = 0, low = 0;
	// pulled-up store/busy wire
	wire hsb_w = !(hsb_oe && !hsb_o) && !busy;
	wire [7:0] dq;
	nvc_host #(.STORE_CYC(60), .PUP_CYC(30), .SOFT_LAT_CYC(40), .RECALL_CYC(60),
		.DRAIN_CYC(120), .STORE_SEQ(SQ), .RECALL_SEQ(RQ)) dut (.clk_sys, .rst_b,
		.supply_ok, .req_valid, .req, .req_ready, .hw_store_req, .rsp_valid, .rsp_rdata,
		.rsp_timeout, .pins, .dq_i(dq), .hsb_i(hsb_w), .hw_store_busy_n_o(hsb_o),
		.hw_store_busy_n_oe(hsb_oe));
	nvc_dev #(.SSEQ(SQ), .RSEQ(RQ)) mdl (.clk_sys, .pins, .supply_ok, .slow, .hsb_w, .busy, .dq);
	initial forever #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (!hsb_w)
			low++;
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// expected read data follows the bench's own copy of the array
	function automatic logic [7:0] exp_data(input logic [14:0] ad);
		return shad[ad];
	endfunction
	task automatic xfer(input logic [2:0] k, input logic [14:0] ad, input logic [7:0] wd,
		input logic t);
		int n;
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (req_ready !== 1'b1 && n < 3000);
		req = '{k[1:0], ad, wd};
		req_valid = !k[2];
		hw_store_req = k[2];
		low = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (rsp_valid !== 1'b1 && n < 3000);
		req_valid = 1'b0;
		hw_store_req = 1'b0;
		chk("timeout flag", 8'(t), 8'(rsp_timeout));
		chk("response wait", 8'h00, 8'(n >= 3000));
	endtask
	task automatic conclude;
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#(25 * 40000);
		errors++;
		conclude();
	end
	initial begin
		void'($urandom(32'hf3dd9110));
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		for (int i = 0; i < 12; i++) begin
			a = i < 2 ? {15{i[0]}} : 15'($urandom);
			d = 8'($urandom);
			shad[a] = d;
			xfer(3'h1, a, d, 1'b0);
			xfer(3'h0, a, '0, 1'b0);
			chk("read data", exp_data(a), rsp_rdata);
		end
		xfer(3'h1, 15'h0123, 8'h5a, 1'b0);
		shad[15'h0123] = 8'h5a;
		xfer(3'h2, '0, '0, 1'b0);
		nvsh = shad;
		chk("store busy", 8'h01, 8'(low > 0));
		xfer(3'h1, 15'h0123, 8'ha5, 1'b0);
		xfer(3'h3, '0, '0, 1'b0);
		shad = nvsh;
		xfer(3'h0, 15'h0123, '0, 1'b0);
		chk("recalled data", exp_data(15'h0123), rsp_rdata);
		xfer(3'h2, '0, '0, 1'b0);
		chk("skipped store busy", 8'h00, 8'(low));
		xfer(3'h1, 15'h0200, 8'h3c, 1'b0);
		shad[15'h0200] = 8'h3c;
		xfer(3'h4, '0, '0, 1'b0);
		chk("hw store busy", 8'h01, 8'(low > 1));
		slow = 1'b1;
		xfer(3'h3, '0, '0, 1'b1);
		slow = 1'b0;
		// let the overlong transfer end so that supply loss meets an idle device
		while (busy)
			@(negedge clk_sys);
		supply_ok = 1'b0;
		repeat (8) @(negedge clk_sys);
		chk("ready at low supply", 8'h00, 8'(req_ready));
		supply_ok = 1'b1;
		xfer(3'h0, 15'h0200, '0, 1'b0);
		chk("data after power-up", exp_data(15'h0200), rsp_rdata);
		rst_b = 1'b0;
		repeat (2) @(negedge clk_sys);
		rst_b = 1'b1;
		xfer(3'h0, 15'h0123, '0, 1'b0);
		chk("data after reset", exp_data(15'h0123), rsp_rdata);
		conclude();
	end
endmodule
`default_nettype wire
